// ---- rtl/cod_pkg.sv ----
// Purpose: Constants and types for the opcode and bus-cycle sequencer.
// Assumes: 50 MHz single clock; software bus is Avalon-MM with byte addresses.
// Notes:   Offsets, reset values and encodings live here only.
//
// What this block does
// [RULE1] Index-to-stack: stack pointer gets index minus one.
// [RULE2] Wait clears interrupt mask, then halts CPU.
// [RULE3] Free cycle: one clock, shown as read.
// [RULE4] Fetch reads next program byte, counter advances.
// [RULE5] Vector read from top page, high first.
// [RULE6] Push writes one byte at stack pointer.
// [RULE7] Pop reads exactly one stack byte.
// [RULE8] Operand read moves one byte inward.
// [RULE9] Operand write moves one byte outward.
// [RULE10] Branch displacement signed, from next instruction.
// [RULE11] Direct mode forces high address byte zero.
// [RULE12] Bit number selects one of eight bits.
// [RULE13] Autoincrement modes bump index after use.
// [RULE14] Stack offset modes add unsigned offset.
// [RULE15] Short index offset is unsigned byte.
// [RULE16] Flags register holds six condition flags.
// [RULE17] Software trap stacks five bytes, ten cycles with refill.
// [RULE18] Halted CPU wakes on unmasked interrupt.

package cod_pkg;

	// -------------------------------------------------------------
	// Register map (byte offsets)
	// -------------------------------------------------------------
	localparam logic [5:0] REG_CTRL    = 6'h00;
	localparam logic [5:0] REG_STATUS  = 6'h04;
	localparam logic [5:0] REG_INDEX   = 6'h08;
	localparam logic [5:0] REG_STACK   = 6'h0c;
	localparam logic [5:0] REG_PC      = 6'h10;
	localparam logic [5:0] REG_FLAGS   = 6'h14;
	localparam logic [5:0] REG_ACC     = 6'h18;
	localparam logic [5:0] REG_AGU_CMD = 6'h1c;
	localparam logic [5:0] REG_AGU_OPD = 6'h20;
	localparam logic [5:0] REG_AGU_EA  = 6'h24;
	localparam logic [5:0] REG_AGU_DAT = 6'h28;

	// -------------------------------------------------------------
	// Reset values and field positions
	// -------------------------------------------------------------
	localparam logic [15:0] RST_PC     = 16'h0000;
	localparam logic [15:0] RST_SP     = 16'h00ff;
	localparam logic [15:0] RST_HX     = 16'h0000;
	localparam logic [7:0]  RST_FLAGS  = 8'h08;
	localparam logic [7:0]  FLAGS_USED = 8'h9f;
	localparam int          FLAG_I     = 3;
	localparam int          CMD_BIT_LO = 4;
	localparam int          CMD_OP_LO  = 8;

	// -------------------------------------------------------------
	// Opcodes, vectors, sequence counts
	// -------------------------------------------------------------
	localparam logic [7:0] OPC_XFER    = 8'h94;
	localparam logic [7:0] OPC_WAIT    = 8'h8f;
	localparam logic [7:0] OPC_TRAP    = 8'h83;
	localparam logic [7:0] VEC_PAGE    = 8'hff;
	localparam logic [7:0] TRAP_VEC_LO = 8'hfc;
	localparam logic [7:0] IRQ_VEC_LO  = 8'hfa;
	localparam logic [2:0] PUSH_LAST   = 3'h4;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_FETCH  = 4'b0001,
		ST_XFER_F = 4'b0010,
		ST_WAIT_F = 4'b0011,
		ST_HALT   = 4'b0100,
		ST_PUSH   = 4'b0101,
		ST_VEC_HI = 4'b0110,
		ST_VEC_LO = 4'b0111,
		ST_TRAP_F = 4'b1000,
		ST_REFILL = 4'b1001,
		ST_OPER   = 4'b1010
	} cod_state_t;

	typedef enum logic [2:0] {
		CYC_FREE   = 3'b000,
		CYC_FETCH  = 3'b001,
		CYC_READ   = 3'b010,
		CYC_WRITE  = 3'b011,
		CYC_PUSH   = 3'b100,
		CYC_POP    = 3'b101,
		CYC_VECTOR = 3'b110,
		CYC_IDLE   = 3'b111
	} cod_cycle_t;

	typedef enum logic [3:0] {
		absolute_mode             = 4'b0000,
		direct_mode               = 4'b0001,
		index_plain_mode          = 4'b0010,
		index_short_offset_mode   = 4'b0011,
		index_long_offset_mode    = 4'b0100,
		index_autoinc_mode        = 4'b0101,
		index_offset_autoinc_mode = 4'b0110,
		stack_short_offset_mode   = 4'b0111,
		stack_long_offset_mode    = 4'b1000,
		relative_mode             = 4'b1001,
		literal_mode              = 4'b1010
	} cod_mode_t;

	typedef enum logic [1:0] {
		AOP_NONE  = 2'b00,
		AOP_READ  = 2'b01,
		AOP_WRITE = 2'b10,
		AOP_POP   = 2'b11
	} cod_aop_t;

endpackage

// ---- rtl/cod_decoder.sv ----
// Purpose: Decode and bus-cycle sequencing for index-to-stack, wait and trap.
// Assumes: Memory answers reads combinationally within the issued cycle.
// Notes:   Software owns the CPU registers only while the sequencer is idle.

`timescale 1ns/1ns

module cod_decoder
	import cod_pkg::*;
#(
	parameter logic [7:0] TRAP_VEC = TRAP_VEC_LO,
	parameter logic [7:0] IRQ_VEC  = IRQ_VEC_LO
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// System memory bus
	output logic      [15:0] mem_addr,
	output logic      [7:0]  mem_wdata,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic      [2:0]  mem_cycle,
	input  wire logic [7:0]  mem_rdata,
	// Interrupt request pin and status
	input  wire logic        irq_pin,
	output logic             cpu_halted
);

	// -------------------------------------------------------------
	// Architectural state
	// -------------------------------------------------------------
	cod_state_t  state;
	cod_state_t  next_state;
	logic [15:0] program_counter_reg;
	logic [15:0] next_pc;
	logic [15:0] stack_pointer_reg;
	logic [15:0] next_sp;
	logic [15:0] index_pair;
	logic [15:0] next_hx;
	logic [7:0]  condition_flags_reg;
	logic [7:0]  next_flags;
	logic [7:0]  acc;
	logic [7:0]  next_acc;
	logic [2:0]  push_idx;
	logic [2:0]  next_push_idx;
	logic        trap_soft;
	logic        next_trap_soft;
	logic        run;
	logic        irq_meta;
	logic        irq_sync;

	// Address unit
	logic [15:0] agu_opnd;
	logic [15:0] agu_ea;
	logic [15:0] next_ea;
	logic [7:0]  agu_mask;
	logic [7:0]  next_mask;
	logic [7:0]  agu_data;
	logic [7:0]  next_data;
	cod_aop_t    agu_op;
	cod_aop_t    next_aop;
	logic [15:0] ea_calc;
	logic        inc_calc;
	logic [7:0]  mask_calc;
	cod_mode_t   cmd_mode;
	logic [2:0]  cmd_bit;
	cod_aop_t    cmd_op;

	// Bus issue
	logic [15:0] next_addr;
	logic [7:0]  next_wdata;
	logic        next_rd;
	logic        next_wr;
	cod_cycle_t  next_cyc;
	logic        bus_wr;
	logic        idle_wr;
	logic [31:0] wmerged;
	logic [31:0] rd_mux;

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// -------------------------------------------------------------
	// Avalon slave: one wait cycle, then a one-cycle answer
	// -------------------------------------------------------------
	assign bus_wr  = avs_write && !avs_waitrequest;
	assign idle_wr = bus_wr && (state == ST_IDLE);
	assign cmd_mode = cod_mode_t'(avs_writedata[3:0]);
	assign cmd_bit  = avs_writedata[CMD_BIT_LO +: 3];
	assign cmd_op   = cod_aop_t'(avs_writedata[CMD_OP_LO +: 2]);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read || avs_write) begin
			avs_waitrequest <= 1'b0;
		end
	end

	always_comb begin
		case (avs_address)
			REG_CTRL:    rd_mux = {31'h0, run};
			REG_STATUS:  rd_mux = {24'h0, 1'b0, mem_cycle, state != ST_IDLE, 2'b00,
				state == ST_HALT};
			REG_INDEX:   rd_mux = {16'h0, index_pair};
			REG_STACK:   rd_mux = {16'h0, stack_pointer_reg};
			REG_PC:      rd_mux = {16'h0, program_counter_reg};
			REG_FLAGS:   rd_mux = {24'h0, condition_flags_reg};
			REG_ACC:     rd_mux = {24'h0, acc};
			REG_AGU_OPD: rd_mux = {16'h0, agu_opnd};
			REG_AGU_EA:  rd_mux = {8'h00, agu_mask, agu_ea};
			REG_AGU_DAT: rd_mux = {24'h0, agu_data};
			default:     rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_mux;
		end
	end

	assign wmerged = be_merge(32'h0, avs_writedata, avs_byteenable);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run <= 1'b0;
		end else if (bus_wr && avs_address == REG_CTRL && avs_byteenable[0]) begin
			run <= avs_writedata[0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			agu_opnd <= 16'h0;
		end else if (bus_wr && avs_address == REG_AGU_OPD) begin
			agu_opnd <= wmerged[15:0] | (agu_opnd & ~{{8{avs_byteenable[1]}},
				{8{avs_byteenable[0]}}});
		end
	end

	// -------------------------------------------------------------
	// Interrupt pin synchroniser
	// -------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_meta <= 1'b0;
			irq_sync <= 1'b0;
		end else begin
			irq_meta <= irq_pin;
			irq_sync <= irq_meta;
		end
	end

	// -------------------------------------------------------------
	// Effective address calculator
	// -------------------------------------------------------------
	always_comb begin
		inc_calc  = 1'b0;
		mask_calc = 8'h01 << cmd_bit; // RULE12
		case (cmd_mode)
			absolute_mode:             ea_calc = agu_opnd;
			direct_mode:               ea_calc = {8'h00, agu_opnd[7:0]}; // RULE11
			index_plain_mode:          ea_calc = index_pair;
			index_short_offset_mode:   ea_calc = index_pair + {8'h00, agu_opnd[7:0]}; // RULE15
			index_long_offset_mode:    ea_calc = index_pair + agu_opnd;
			index_autoinc_mode: begin
				ea_calc  = index_pair; // RULE13
				inc_calc = 1'b1;
			end
			index_offset_autoinc_mode: begin
				ea_calc  = index_pair + {8'h00, agu_opnd[7:0]}; // RULE13
				inc_calc = 1'b1;
			end
			stack_short_offset_mode:   ea_calc = stack_pointer_reg + {8'h00, agu_opnd[7:0]}; // RULE14
			stack_long_offset_mode:    ea_calc = stack_pointer_reg + agu_opnd; // RULE14
			// The counter already points past the branch, so the base is the next instruction.
			relative_mode:             ea_calc = program_counter_reg +
				{{8{agu_opnd[7]}}, agu_opnd[7:0]}; // RULE10
			literal_mode:              ea_calc = program_counter_reg;
			default:                   ea_calc = agu_opnd;
		endcase
	end

	// -------------------------------------------------------------
	// Sequencer: pick the next cycle, then issue its bus request
	// -------------------------------------------------------------
	always_comb begin
		next_state     = state;
		next_pc        = program_counter_reg;
		next_sp        = stack_pointer_reg;
		next_hx        = index_pair;
		next_flags     = condition_flags_reg;
		next_acc       = acc;
		next_push_idx  = push_idx;
		next_trap_soft = trap_soft;
		next_ea        = agu_ea;
		next_mask      = agu_mask;
		next_data      = agu_data;
		next_aop       = agu_op;
		next_addr      = mem_addr;
		next_wdata     = mem_wdata;
		next_rd        = 1'b0;
		next_wr        = 1'b0;
		next_cyc       = CYC_IDLE;
		if (idle_wr) begin
			case (avs_address)
				REG_INDEX: next_hx = wmerged[15:0] | (index_pair & ~{
					{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}});
				REG_STACK: next_sp = wmerged[15:0] | (stack_pointer_reg & ~{
					{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}});
				REG_PC:    next_pc = wmerged[15:0] | (program_counter_reg & ~{
					{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}});
				REG_FLAGS: if (avs_byteenable[0]) next_flags = avs_writedata[7:0] & FLAGS_USED; // RULE16
				REG_ACC:   if (avs_byteenable[0]) next_acc = avs_writedata[7:0];
				default:   next_acc = acc;
			endcase
		end
		case (state)
			ST_IDLE: begin
				if (run) begin
					next_state = ST_FETCH;
				end else if (idle_wr && avs_address == REG_AGU_CMD) begin
					next_ea   = ea_calc;
					next_mask = mask_calc;
					next_aop  = cmd_op;
					if (inc_calc) begin
						next_hx = index_pair + 16'h0001; // RULE13
					end
					if (cmd_op != AOP_NONE) begin
						next_state = ST_OPER;
					end
				end
			end
			ST_FETCH: begin
				case (mem_rdata)
					OPC_XFER: next_state = ST_XFER_F;
					OPC_WAIT: next_state = ST_WAIT_F;
					OPC_TRAP: begin
						next_state     = ST_PUSH;
						next_push_idx  = 3'h0;
						next_trap_soft = 1'b1;
					end
					default: begin
						// Stopping discards the byte, so step back to refetch it later.
						if (!run) begin
							next_state = ST_IDLE;
							next_pc    = program_counter_reg - 16'h0001;
						end
					end
				endcase
			end
			ST_XFER_F: begin
				next_sp    = index_pair - 16'h0001; // RULE1
				next_state = ST_FETCH; // RULE1
			end
			ST_WAIT_F: begin
				next_flags[FLAG_I] = 1'b0; // RULE2
				next_state         = ST_HALT; // RULE2
			end
			ST_HALT: begin
				if (irq_sync && !condition_flags_reg[FLAG_I]) begin
					next_state     = ST_PUSH; // RULE18
					next_push_idx  = 3'h0;
					next_trap_soft = 1'b0;
				end else if (!run) begin
					next_state = ST_IDLE;
				end
			end
			ST_PUSH: begin
				if (push_idx == PUSH_LAST) begin
					next_flags[FLAG_I] = 1'b1; // RULE17
					next_state         = ST_VEC_HI;
				end else begin
					next_push_idx = push_idx + 3'h1;
				end
			end
			ST_VEC_HI: begin
				next_pc[15:8] = mem_rdata; // RULE5
				next_state    = ST_VEC_LO;
			end
			ST_VEC_LO: begin
				next_pc[7:0] = mem_rdata; // RULE5
				next_state   = ST_TRAP_F;
			end
			ST_TRAP_F: next_state = ST_REFILL;
			ST_REFILL: next_state = ST_FETCH;
			ST_OPER: begin
				if (agu_op != AOP_WRITE) begin
					next_data = mem_rdata; // RULE7 RULE8
				end
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		case (next_state)
			ST_FETCH: begin
				next_addr = next_pc; // RULE4
				next_pc   = next_pc + 16'h0001; // RULE4
				next_rd   = 1'b1;
				next_cyc  = CYC_FETCH;
			end
			ST_REFILL: begin
				next_addr = next_pc;
				next_rd   = 1'b1;
				next_cyc  = CYC_FETCH;
			end
			ST_XFER_F, ST_WAIT_F, ST_TRAP_F: begin
				next_addr = next_pc;
				next_rd   = 1'b1; // RULE3
				next_cyc  = CYC_FREE; // RULE3
			end
			ST_PUSH: begin
				next_addr = next_sp; // RULE6
				next_sp   = next_sp - 16'h0001;
				next_wr   = 1'b1;
				next_cyc  = CYC_PUSH;
				case (next_push_idx)
					3'h0:    next_wdata = next_pc[7:0]; // RULE17
					3'h1:    next_wdata = next_pc[15:8];
					3'h2:    next_wdata = next_hx[7:0];
					3'h3:    next_wdata = next_acc;
					default: next_wdata = next_flags;
				endcase
			end
			ST_VEC_HI, ST_VEC_LO: begin
				next_addr = {VEC_PAGE, next_trap_soft ? TRAP_VEC : IRQ_VEC}; // RULE5
				if (next_state == ST_VEC_LO) begin
					next_addr = mem_addr + 16'h0001; // RULE5
				end
				next_rd  = 1'b1;
				next_cyc = CYC_VECTOR;
			end
			ST_OPER: begin
				case (next_aop)
					AOP_WRITE: begin
						next_addr  = next_ea;
						next_wdata = next_acc; // RULE9
						next_wr    = 1'b1;
						next_cyc   = CYC_WRITE;
					end
					AOP_POP: begin
						next_sp   = next_sp + 16'h0001; // RULE7
						next_addr = next_sp;
						next_rd   = 1'b1;
						next_cyc  = CYC_POP;
					end
					default: begin
						next_addr = next_ea; // RULE8
						next_rd   = 1'b1;
						next_cyc  = CYC_READ;
					end
				endcase
			end
			default: next_cyc = CYC_IDLE;
		endcase
	end

	// -------------------------------------------------------------
	// State registers
	// -------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state     <= ST_IDLE;
			push_idx  <= 3'h0;
			trap_soft <= 1'b0;
		end else begin
			state     <= next_state;
			push_idx  <= next_push_idx;
			trap_soft <= next_trap_soft;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			program_counter_reg <= RST_PC;
			stack_pointer_reg   <= RST_SP;
			index_pair          <= RST_HX;
			condition_flags_reg <= RST_FLAGS;
			acc                 <= 8'h00;
		end else begin
			program_counter_reg <= next_pc;
			stack_pointer_reg   <= next_sp;
			index_pair          <= next_hx;
			condition_flags_reg <= next_flags;
			acc                 <= next_acc;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			agu_ea   <= 16'h0;
			agu_mask <= 8'h01;
			agu_data <= 8'h00;
			agu_op   <= AOP_NONE;
		end else begin
			agu_ea   <= next_ea;
			agu_mask <= next_mask;
			agu_data <= next_data;
			agu_op   <= next_aop;
		end
	end

	// Bus outputs are registered one cycle ahead so memory sees clean levels.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_addr   <= 16'h0;
			mem_wdata  <= 8'h00;
			mem_rd     <= 1'b0;
			mem_wr     <= 1'b0;
			mem_cycle  <= CYC_IDLE;
			cpu_halted <= 1'b0;
		end else begin
			mem_addr   <= next_addr;
			mem_wdata  <= next_wdata;
			mem_rd     <= next_rd;
			mem_wr     <= next_wr;
			mem_cycle  <= next_cyc;
			cpu_halted <= next_state == ST_HALT;
		end
	end

endmodule

// ---- tb/cod_decoder_chk.sv ----
// Purpose: Port-level checks of the opcode and bus-cycle sequencer.
// Assumes: One clock, reset asynchronous and active high.
// Notes:   Opcode-triggered checks skip the refill fetch that follows a free cycle.
`timescale 1ns/1ns
module cod_decoder_chk
	import cod_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Register bus
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Memory bus
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  mem_wdata,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic [2:0]  mem_cycle,
	input wire logic [7:0]  mem_rdata,
	// Interrupt and status
	input wire logic        irq_pin,
	input wire logic        cpu_halted
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_free_read: assert property (mem_cycle == CYC_FREE |-> mem_rd && !mem_wr)
		else $error("free cycle is not a read");
	a_free_single: assert property (mem_cycle == CYC_FREE |=> mem_cycle != CYC_FREE)
		else $error("free cycle longer than one clock");
	a_fetch_next: assert property ((mem_cycle == CYC_FETCH) ##1 (mem_cycle == CYC_FREE)
		##1 (mem_cycle == CYC_FETCH) |-> mem_addr == $past(mem_addr, 2) + 16'h0001)
		else $error("fetch did not advance by one");
	a_vec_page: assert property (mem_cycle == CYC_VECTOR |-> mem_rd && mem_addr[15:8] == VEC_PAGE)
		else $error("vector read outside top page");
	a_vec_order: assert property ((mem_cycle == CYC_VECTOR) ##1 (mem_cycle == CYC_VECTOR)
		|-> mem_addr == $past(mem_addr) + 16'h0001)
		else $error("vector bytes out of order");
	a_push_write: assert property (mem_cycle == CYC_PUSH |-> mem_wr && !mem_rd)
		else $error("push is not a single write");
	a_push_down: assert property ((mem_cycle == CYC_PUSH) ##1 (mem_cycle == CYC_PUSH)
		|-> mem_addr == $past(mem_addr) - 16'h0001)
		else $error("push address not descending");
	a_wr_strobe: assert property (mem_wr |-> mem_cycle == CYC_PUSH || mem_cycle == CYC_WRITE)
		else $error("write strobe in a read cycle");
	a_oper_read: assert property ((mem_cycle == CYC_POP || mem_cycle == CYC_READ)
		|-> mem_rd && !mem_wr)
		else $error("operand read is not a single read");
	a_trap_seq: assert property (mem_cycle == CYC_FETCH && mem_rd && mem_rdata == OPC_TRAP
		&& $past(mem_cycle) != CYC_FREE |=> (mem_cycle == CYC_PUSH) [*5]
		##1 (mem_cycle == CYC_VECTOR) [*2] ##1 mem_cycle == CYC_FREE)
		else $error("trap cycle sequence wrong");
	a_wait_halt: assert property (mem_cycle == CYC_FETCH && mem_rd && mem_rdata == OPC_WAIT
		&& $past(mem_cycle) != CYC_FREE |=> mem_cycle == CYC_FREE ##[1:2] cpu_halted)
		else $error("wait did not halt");
	a_av_wait: assert property (($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest
		##1 !avs_waitrequest ##1 avs_waitrequest)
		else $error("register access not one wait state");
endmodule

bind cod_decoder cod_decoder_chk u_chk (
	.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr),
	.mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_cycle(mem_cycle),
	.mem_rdata(mem_rdata), .irq_pin(irq_pin), .cpu_halted(cpu_halted)
);

// ---- tb/cod_mem_model.sv ----
// Purpose: Flat 64 KiB system memory seen by the sequencer.
// Assumes: Reads answer in the cycle the strobe is high.
// Notes:   Preloaded with a pattern: each byte is its low address byte XOR its high address byte.
`timescale 1ns/1ns
module cod_mem_model (
	// Clock
	input wire logic        clk,
	// Memory bus
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  mem_wdata,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	output logic     [7:0]  mem_rdata
);
	logic [7:0] m [0:65535];
	logic [7:0] last;

	initial begin
		for (int i = 0; i < 65536; i++) begin
			m[i] = i[7:0] ^ i[15:8];
		end
		last = 8'h00;
	end

	// An idle bus does not keep its last byte, so a stale sample shows up as a wrong value.
	assign mem_rdata = mem_rd ? m[mem_addr] : ~last;

	always @(posedge clk) begin
		if (mem_wr) begin
			m[mem_addr] <= mem_wdata;
		end
		if (mem_rd) begin
			last <= m[mem_addr];
		end
	end

	task automatic load(input logic [15:0] a, input logic [7:0] d);
		m[a] = d;
	endtask
endmodule

// ---- tb/cpu_opcode_cycle_decoder_tb.sv ----
// Purpose: Self-checking bench for the opcode and bus-cycle sequencer.
// Assumes: Relative and literal modes are tried before the CPU runs, so PC is zero.
// Notes:   The program is loaded after the address-unit tests so stray writes cannot hit it.
`timescale 1ns/1ns
module cpu_opcode_cycle_decoder_tb
	import cod_pkg::*;
;
	logic        clk, rst, avs_read, avs_write, mem_rd, mem_wr, irq_pin, cpu_halted;
	logic        avs_waitrequest;
	logic [5:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, v, rd, seed;
	logic [3:0]  avs_byteenable;
	logic [15:0] mem_addr, hx, sp, opd, ea;
	logic [7:0]  mem_wdata, mem_rdata, acc, fl, old;
	logic [2:0]  mem_cycle, bt;
	logic [1:0]  op;
	int          fail_count, checked, bz;
	logic [5:0]  ra [6] = '{REG_PC, REG_STACK, REG_FLAGS, REG_INDEX, REG_STATUS, 6'h2c};
	logic [31:0] rv [6] = '{32'h0, 32'hff, 32'h8, 32'h0, 32'h70, 32'h0};
	logic [7:0]  fr [10];

	cod_decoder u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_cycle(mem_cycle),
		.mem_rdata(mem_rdata), .irq_pin(irq_pin), .cpu_halted(cpu_halted));
	cod_mem_model u_mem (.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [15:0] ea_of(input logic [3:0] md, input logic [15:0] o, x, s);
		case (md)
			4'h0: return o;
			4'h1: return {8'h00, o[7:0]};
			4'h2, 4'h5: return x;
			4'h3, 4'h6: return x + {8'h00, o[7:0]};
			4'h4: return x + o;
			4'h7: return s + {8'h00, o[7:0]};
			4'h8: return s + o;
			4'h9: return {{8{o[7]}}, o[7:0]};
			default: return 16'h0000;
		endcase
	endfunction

	task automatic conclude();
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic timeout();
		fail_count++;
		$display("CHECK FAILED wait expected done seen timeout");
		conclude();
	endtask

	task automatic av(input logic w, input logic [5:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !w;
		avs_write <= w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) timeout();
	endtask

	task automatic wait_halt(input logic lvl);
		int n;
		n = 0;
		while (cpu_halted !== lvl && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n >= 300) timeout();
	endtask

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial begin
		seed = 32'ha1af1acd;
		fail_count = 0;
		checked = 0;
		rst = 1'b1;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		irq_pin = 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			av(1'b0, ra[i], 32'h0);
			chk("reset value", rd, rv[i]);
		end
		v = rnd();
		av(1'b1, REG_FLAGS, v);
		av(1'b0, REG_FLAGS, 32'h0);
		chk("flags bits", rd, v & 32'h9f);
		for (int md = 0; md < 11; md++) begin
			v = rnd();
			hx = {2'b10, v[13:0]};
			sp = {2'b10, v[29:16]};
			v = rnd();
			opd = v[15:0];
			if (md == 9) opd[7:0] = 8'h80;
			bt = v[18:16];
			acc = v[31:24];
			op = (md == 2) ? 2'd0 : (md == 0) ? 2'd2 : (md == 1) ? 2'd3 : 2'd1;
			ea = ea_of(md[3:0], opd, hx, sp);
			old = (op == 2'd3) ? u_mem.m[sp + 16'h1] : u_mem.m[ea];
			av(1'b1, REG_INDEX, {16'h0, hx});
			av(1'b1, REG_STACK, {16'h0, sp});
			av(1'b1, REG_ACC, {24'h0, acc});
			av(1'b1, REG_AGU_OPD, {16'h0, opd});
			av(1'b1, REG_AGU_CMD, {22'h0, op, 1'b0, bt, md[3:0]});
			bz = 0;
			do begin
				av(1'b0, REG_STATUS, 32'h0);
				bz++;
			end while (rd[3] !== 1'b0 && bz < 20);
			if (bz >= 20) timeout();
			av(1'b0, REG_AGU_EA, 32'h0);
			chk("agu address", rd, {8'h00, 8'h01 << bt, ea});
			if (op == 2'd1 || op == 2'd3) begin
				av(1'b0, REG_AGU_DAT, 32'h0);
				chk("agu data", rd, {24'h0, old});
			end
			if (op == 2'd2) chk("operand write", {24'h0, u_mem.m[ea]}, {24'h0, acc});
			av(1'b0, REG_INDEX, 32'h0);
			chk("index", rd, {16'h0, (md == 5 || md == 6) ? hx + 16'h1 : hx});
			av(1'b0, REG_STACK, 32'h0);
			chk("stack", rd, {16'h0, (op == 2'd3) ? sp + 16'h1 : sp});
		end
		v = rnd();
		hx = {2'b10, v[13:0]};
		acc = v[23:16];
		fl = (v[31:24] & 8'h97) | 8'h08;
		u_mem.load(16'h0000, OPC_XFER);
		u_mem.load(16'h0001, OPC_WAIT);
		u_mem.load({VEC_PAGE, IRQ_VEC_LO}, 8'h01);
		u_mem.load({VEC_PAGE, IRQ_VEC_LO} + 16'h1, 8'h00);
		u_mem.load(16'h0100, OPC_TRAP);
		u_mem.load({VEC_PAGE, TRAP_VEC_LO}, 8'h02);
		u_mem.load({VEC_PAGE, TRAP_VEC_LO} + 16'h1, 8'h00);
		u_mem.load(16'h0200, OPC_WAIT);
		av(1'b1, REG_INDEX, {16'h0, hx});
		av(1'b1, REG_ACC, {24'h0, acc});
		av(1'b1, REG_FLAGS, {24'h0, fl});
		av(1'b1, REG_CTRL, 32'h1);
		wait_halt(1'b1);
		av(1'b0, REG_STACK, 32'h0);
		chk("stack after transfer", rd, {16'h0, hx - 16'h1});
		av(1'b0, REG_FLAGS, 32'h0);
		chk("flags after wait", rd, {24'h0, fl & 8'hf7});
		irq_pin <= 1'b1;
		wait_halt(1'b0);
		irq_pin <= 1'b0;
		wait_halt(1'b1);
		fr = '{8'h02, 8'h00, hx[7:0], acc, fl & 8'hf7, 8'h01, 8'h01, hx[7:0], acc, fl};
		for (int k = 0; k < 10; k++) begin
			chk("stacked byte", {24'h0, u_mem.m[hx - 16'h1 - k[15:0]]}, {24'h0, fr[k]});
		end
		av(1'b0, REG_STACK, 32'h0);
		chk("stack after traps", rd, {16'h0, hx - 16'h000b});
		av(1'b1, REG_CTRL, 32'h0);
		conclude();
	end
endmodule
